// ==== inc/lid_pkg.sv ====
// Shared constants and types for the legacy IO LPC/ISA positive decoder.
// Assumes a function 0 configuration space reached by dword with byte enables.
package lid_pkg;

   // ****************************************
   // Configuration offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_INTR_CFG = 8'h4B;
   localparam logic [7:0] OFF_DEC_LEGACY_A = 8'h51;
   localparam logic [7:0] OFF_DEC_SERIAL = 8'h52;
   localparam logic [7:0] OFF_DEC_AUDIO_MIDI = 8'h53;
   localparam logic [7:0] OFF_DEC_SOUND_SIO = 8'h54;
   localparam logic [7:0] OFF_DEC_GAME_A = 8'h55;
   localparam logic [7:0] OFF_DEC_GAME_B = 8'h56;
   localparam logic [7:0] OFF_GENERIC_B0 = 8'h58;
   localparam logic [7:0] OFF_GENERIC_B1 = 8'h59;

   // ****************************************
   // Reset values and writable bits
   // ****************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_GENERIC_WORD = 32'h0000_DE01;
   localparam logic [6:0] RST_GENERIC_BASE = RST_GENERIC_WORD[15:9];
   localparam logic [8:0] GENERIC_LOW_BITS = RST_GENERIC_WORD[8:0];
   localparam logic [6:0] GENERIC_OFF = 7'h00;
   localparam logic [7:0] WMASK_INTR_CFG = 8'h1F;
   localparam logic [7:0] WMASK_LEGACY_A = 8'hFB;
   localparam logic [7:0] WMASK_SERIAL = 8'hFF;
   localparam logic [7:0] WMASK_AUDIO_MIDI = 8'h7F;
   localparam logic [7:0] WMASK_SOUND_SIO = 8'h37;
   localparam logic [7:0] WMASK_GAME = 8'h1F;

   // ****************************************
   // Fixed IO addresses and window sizes
   // ****************************************
   localparam logic [15:0] PAR_BASE_0 = 16'h03BC;
   localparam logic [15:0] PAR_BASE_1 = 16'h0378;
   localparam logic [15:0] PAR_BASE_2 = 16'h0278;
   localparam logic [15:0] PAR_LEN_0 = 16'h0004;
   localparam logic [15:0] PAR_LEN_N = 16'h0008;
   localparam logic [15:0] PAR_EXT_STEP = 16'h0400;
   localparam logic [15:0] PAR_WR_ISA_PORT = 16'h0279;
   localparam logic [1:0] PAR_SEL_NONE = 2'b11;
   localparam logic [1:0] PAR_SEL_278 = 2'b10;
   localparam logic [15:0] FLOPPY_A_LO = 16'h03F0;
   localparam logic [15:0] FLOPPY_A_HI = 16'h03F5;
   localparam logic [15:0] FLOPPY_A_EXTRA = 16'h03F7;
   localparam logic [15:0] FLOPPY_B_LO = 16'h0370;
   localparam logic [15:0] FLOPPY_B_HI = 16'h0375;
   localparam logic [15:0] FLOPPY_B_EXTRA = 16'h0377;
   localparam logic [15:0] KBD_DATA_PORT = 16'h0060;
   localparam logic [15:0] KBD_CMD_PORT = 16'h0064;
   localparam logic [15:0] EC_DATA_PORT = 16'h0062;
   localparam logic [15:0] EC_CMD_PORT = 16'h0066;
   localparam logic [15:0] SERIAL_BASE_0 = 16'h03F8;
   localparam logic [15:0] SERIAL_BASE_1 = 16'h02F8;
   localparam logic [15:0] SERIAL_BASE_2 = 16'h0220;
   localparam logic [15:0] SERIAL_BASE_3 = 16'h0228;
   localparam logic [15:0] SERIAL_BASE_4 = 16'h0238;
   localparam logic [15:0] SERIAL_BASE_5 = 16'h02E8;
   localparam logic [15:0] SERIAL_BASE_6 = 16'h0338;
   localparam logic [15:0] SERIAL_BASE_7 = 16'h03E8;
   localparam logic [15:0] SERIAL_LEN = 16'h0008;
   localparam logic [15:0] AUDIO_BASE = 16'h0220;
   localparam logic [15:0] AUDIO_STEP = 16'h0020;
   localparam logic [15:0] AUDIO_LEN = 16'h0014;
   localparam logic [15:0] AUDIO_LEGACY_LO = 16'h0388;
   localparam logic [15:0] AUDIO_LEGACY_HI = 16'h0389;
   localparam logic [15:0] MIDI_BASE = 16'h0300;
   localparam logic [15:0] MIDI_STEP = 16'h0010;
   localparam logic [15:0] MIDI_LEN = 16'h0002;
   localparam logic [15:0] SOUND_BASE_0 = 16'h0530;
   localparam logic [15:0] SOUND_BASE_1 = 16'h0604;
   localparam logic [15:0] SOUND_BASE_2 = 16'h0E80;
   localparam logic [15:0] SOUND_BASE_3 = 16'h0F40;
   localparam logic [15:0] SOUND_LEN = 16'h0008;
   localparam logic [15:0] SIO_CFG_LO = 16'h002E;
   localparam logic [15:0] SIO_CFG_HI = 16'h002F;
   localparam logic [15:0] ALT_SIO_CFG_LO = 16'h004E;
   localparam logic [15:0] ALT_SIO_CFG_HI = 16'h004F;
   localparam logic [11:0] GAME_PAGE = 12'h020;

   // ****************************************
   // Register layouts
   // ****************************************
   typedef struct packed {
      logic [2:0] rsvd;
      logic [1:0] intrClockSelect;
      logic sciRedirect;
      logic smiRedirect;
      logic intrCtrlEnable;
   } lid_intr_cfg_s;

   typedef struct packed {
      logic ecRoute;
      logic keyboardCtrlRoute;
      logic floppySecondaryRoute;
      logic floppyPrimaryRoute;
      logic extendedParallelEnable;
      logic rsvd;
      logic [1:0] parallelWindowSelect;
   } lid_legacy_a_s;

   typedef struct packed {
      logic serialBRouteEn;
      logic [2:0] serialBWindow;
      logic serialARouteEn;
      logic [2:0] serialAWindow;
   } lid_serial_s;

   typedef struct packed {
      logic rsvd;
      logic midiRouteEn;
      logic [1:0] midiWindow;
      logic audioLegacyRoute;
      logic audioRouteEn;
      logic [1:0] audioWindow;
   } lid_audio_midi_s;

   typedef struct packed {
      logic [1:0] rsvdHi;
      logic altSuperioCfgRoute;
      logic superioCfgRoute;
      logic rsvdLo;
      logic soundSystemRouteEn;
      logic [1:0] soundSystemWindow;
   } lid_sound_sio_s;

   typedef struct packed {
      logic [2:0] rsvd;
      logic routeEn;
      logic [3:0] offset;
   } lid_game_s;

   typedef struct packed {
      lid_intr_cfg_s intrCfg;
      lid_legacy_a_s legacyA;
      lid_serial_s serial;
      lid_audio_midi_s audioMidi;
      lid_sound_sio_s soundSio;
      lid_game_s gameA;
      lid_game_s gameB;
      logic [6:0] genericWindowBase;
   } lid_cfg_s;

   // Outcome of one IO decode
   typedef struct packed {
      logic hit;
      logic toLpc;
      logic toIsa;
      logic toUsb;
   } lid_route_s;

endpackage : lid_pkg

// ==== rtl/lid_legacy_io_decoder.sv ====
// Positive decoder for legacy IO and interrupt-controller memory cycles.
// Assumes the PCI target logic presents one decoded cycle at a time on mclk,
// and config cycles to function 0 arrive as dword address plus byte enables.
`timescale 1ns/1ps

module lid_legacy_io_decoder
   import lid_pkg::*;
#(
   parameter logic [31:0] INTR_WIN_BASE = 32'hFEC0_0000,
   parameter logic [31:0] INTR_WIN_SIZE = 32'h0000_1000
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Configuration access, function 0
   input wire logic cfgSel,
   input wire logic cfgWr,
   input wire logic [5:0] cfgDwordAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   // IO cycle to decode
   input wire logic ioReq,
   input wire logic [15:0] ioAddr,
   input wire logic ioWrite,
   input wire logic usbEmulationControl,
   // IO decode result
   output logic ioDone,
   output logic ioHit,
   output logic ioToLpc,
   output logic ioToIsa,
   output logic ioToUsb,
   // Memory cycle to decode
   input wire logic memReq,
   input wire logic [31:0] memAddr,
   // Memory decode result
   output logic memDone,
   output logic memInWindow,
   output logic memToLegacy,
   output logic memToIntr,
   // Interrupt message bus control
   output logic intrMsgBusEnable
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      lid_cfg_s cfg;
      logic [31:0] rdData;
      logic rdValid;
      logic ioDone;
      lid_route_s io;
      logic memDone;
      logic memInWindow;
      logic memToLegacy;
      logic memToIntr;
   } lid_state_s;

   lid_state_s state;
   lid_state_s next_state;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic inWin(input logic [15:0] addr, input logic [15:0] base,
                                  input logic [15:0] len);
      logic [15:0] delta;
      delta = addr - base;
      inWin = (addr >= base) && (delta < len);
   endfunction : inWin

   function automatic logic [15:0] serialBase(input logic [2:0] sel);
      case (sel)
         3'b000: serialBase = SERIAL_BASE_0;
         3'b001: serialBase = SERIAL_BASE_1;
         3'b010: serialBase = SERIAL_BASE_2;
         3'b011: serialBase = SERIAL_BASE_3;
         3'b100: serialBase = SERIAL_BASE_4;
         3'b101: serialBase = SERIAL_BASE_5;
         3'b110: serialBase = SERIAL_BASE_6;
         default: serialBase = SERIAL_BASE_7;
      endcase
   endfunction : serialBase

   function automatic logic [15:0] soundBase(input logic [1:0] sel);
      case (sel)
         2'b00: soundBase = SOUND_BASE_0;
         2'b01: soundBase = SOUND_BASE_1;
         2'b10: soundBase = SOUND_BASE_2;
         default: soundBase = SOUND_BASE_3;
      endcase
   endfunction : soundBase

   // Readback of one config byte; unmapped bytes read zero
   function automatic logic [7:0] readByte(input lid_cfg_s cfg, input logic [7:0] off);
      case (off)
         OFF_INTR_CFG: readByte = cfg.intrCfg & WMASK_INTR_CFG;
         OFF_DEC_LEGACY_A: readByte = cfg.legacyA & WMASK_LEGACY_A;
         OFF_DEC_SERIAL: readByte = cfg.serial & WMASK_SERIAL;
         OFF_DEC_AUDIO_MIDI: readByte = cfg.audioMidi & WMASK_AUDIO_MIDI;
         OFF_DEC_SOUND_SIO: readByte = cfg.soundSio & WMASK_SOUND_SIO;
         OFF_DEC_GAME_A: readByte = cfg.gameA & WMASK_GAME;
         OFF_DEC_GAME_B: readByte = cfg.gameB & WMASK_GAME;
         OFF_GENERIC_B0: readByte = GENERIC_LOW_BITS[7:0];
         OFF_GENERIC_B1: readByte = {cfg.genericWindowBase, GENERIC_LOW_BITS[8]};
         default: readByte = RST_BYTE;
      endcase
   endfunction : readByte

   // ****************************************
   // IO window decode
   // ****************************************
   function automatic lid_route_s decodeIo(input lid_cfg_s cfg, input logic [15:0] addr,
                                           input logic wr, input logic usbEmu);
      lid_route_s r;
      logic [15:0] parBase;
      logic [15:0] parLen;
      logic parOn;
      logic lpc;
      logic isa;
      logic [15:0] audBase;
      logic [15:0] midBase;
      r = '0;
      lpc = 1'b0;
      isa = 1'b0;
      parOn = 1'b1;
      parLen = PAR_LEN_N;
      case (cfg.legacyA.parallelWindowSelect)
         2'b00: begin
            parBase = PAR_BASE_0;
            parLen = PAR_LEN_0;
         end
         2'b01: parBase = PAR_BASE_1;
         2'b10: parBase = PAR_BASE_2;
         default: begin
            parBase = PAR_BASE_0;
            parOn = 1'b0;
         end
      endcase
      if (parOn && inWin(addr, parBase, parLen)) begin
         if (cfg.legacyA.parallelWindowSelect == PAR_SEL_278 && addr == PAR_WR_ISA_PORT
             && wr) begin
            isa = 1'b1;
         end else begin
            lpc = 1'b1;
         end
      end
      if (parOn && cfg.legacyA.extendedParallelEnable
          && inWin(addr, parBase + PAR_EXT_STEP, parLen)) begin
         lpc = 1'b1;
      end
      // Floppy controllers
      if ((addr >= FLOPPY_A_LO && addr <= FLOPPY_A_HI) || addr == FLOPPY_A_EXTRA) begin
         lpc = lpc | cfg.legacyA.floppyPrimaryRoute;
         isa = isa | ~cfg.legacyA.floppyPrimaryRoute;
      end
      if ((addr >= FLOPPY_B_LO && addr <= FLOPPY_B_HI) || addr == FLOPPY_B_EXTRA) begin
         lpc = lpc | cfg.legacyA.floppySecondaryRoute;
         isa = isa | ~cfg.legacyA.floppySecondaryRoute;
      end
      // Keyboard ports leave the LPC/ISA choice entirely when emulated
      if (addr == KBD_DATA_PORT || addr == KBD_CMD_PORT) begin
         if (usbEmu) begin
            r.toUsb = 1'b1;
         end else begin
            lpc = lpc | cfg.legacyA.keyboardCtrlRoute;
            isa = isa | ~cfg.legacyA.keyboardCtrlRoute;
         end
      end
      if (addr == EC_DATA_PORT || addr == EC_CMD_PORT) begin
         lpc = lpc | cfg.legacyA.ecRoute;
         isa = isa | ~cfg.legacyA.ecRoute;
      end
      // Serial ports
      if (inWin(addr, serialBase(cfg.serial.serialAWindow), SERIAL_LEN)) begin
         lpc = lpc | cfg.serial.serialARouteEn;
         isa = isa | ~cfg.serial.serialARouteEn;
      end
      if (inWin(addr, serialBase(cfg.serial.serialBWindow), SERIAL_LEN)) begin
         lpc = lpc | cfg.serial.serialBRouteEn;
         isa = isa | ~cfg.serial.serialBRouteEn;
      end
      // Audio, legacy audio and MIDI
      audBase = AUDIO_BASE + AUDIO_STEP * {14'h0000, cfg.audioMidi.audioWindow};
      if (inWin(addr, audBase, AUDIO_LEN)) begin
         lpc = lpc | cfg.audioMidi.audioRouteEn;
         isa = isa | ~cfg.audioMidi.audioRouteEn;
      end
      if (addr >= AUDIO_LEGACY_LO && addr <= AUDIO_LEGACY_HI) begin
         lpc = lpc | cfg.audioMidi.audioLegacyRoute;
         isa = isa | ~cfg.audioMidi.audioLegacyRoute;
      end
      midBase = MIDI_BASE + MIDI_STEP * {14'h0000, cfg.audioMidi.midiWindow};
      if (inWin(addr, midBase, MIDI_LEN)) begin
         lpc = lpc | cfg.audioMidi.midiRouteEn;
         isa = isa | ~cfg.audioMidi.midiRouteEn;
      end
      // Sound system and super-IO configuration ports
      if (inWin(addr, soundBase(cfg.soundSio.soundSystemWindow), SOUND_LEN)) begin
         lpc = lpc | cfg.soundSio.soundSystemRouteEn;
         isa = isa | ~cfg.soundSio.soundSystemRouteEn;
      end
      if (addr >= SIO_CFG_LO && addr <= SIO_CFG_HI) begin
         lpc = lpc | cfg.soundSio.superioCfgRoute;
         isa = isa | ~cfg.soundSio.superioCfgRoute;
      end
      if (addr >= ALT_SIO_CFG_LO && addr <= ALT_SIO_CFG_HI) begin
         lpc = lpc | cfg.soundSio.altSuperioCfgRoute;
         isa = isa | ~cfg.soundSio.altSuperioCfgRoute;
      end
      // Game ports, one byte each
      if (addr == {GAME_PAGE, cfg.gameA.offset}) begin
         lpc = lpc | cfg.gameA.routeEn;
         isa = isa | ~cfg.gameA.routeEn;
      end
      if (addr == {GAME_PAGE, cfg.gameB.offset}) begin
         lpc = lpc | cfg.gameB.routeEn;
         isa = isa | ~cfg.gameB.routeEn;
      end
      // Generic window has no ISA fallback of its own
      if (cfg.genericWindowBase != GENERIC_OFF
          && addr[15:9] == cfg.genericWindowBase) begin
         lpc = 1'b1;
      end
      // Overlaps: LPC wins; unmatched cycles still go to ISA
      r.hit = lpc | isa | r.toUsb;
      r.toLpc = lpc & ~r.toUsb;
      r.toIsa = ~lpc & ~r.toUsb;
      decodeIo = r;
   endfunction : decodeIo

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [7:0] off;
      logic [7:0] wb;
      logic [31:0] memDelta;
      off = '0;
      wb = '0;
      memDelta = '0;
      next_state = state;
      next_state.rdValid = 1'b0;
      next_state.ioDone = 1'b0;
      next_state.memDone = 1'b0;

      // Config access, byte lanes handled one at a time
      if (cfgSel) begin
         for (int lane = 0; lane < 4; lane++) begin
            off = {cfgDwordAddr, lane[1:0]};
            wb = cfgWrData[lane*8 +: 8];
            if (cfgWr && cfgByteEn[lane]) begin
               case (off)
                  OFF_INTR_CFG: next_state.cfg.intrCfg = wb & WMASK_INTR_CFG;
                  OFF_DEC_LEGACY_A: next_state.cfg.legacyA = wb & WMASK_LEGACY_A;
                  OFF_DEC_SERIAL: next_state.cfg.serial = wb & WMASK_SERIAL;
                  OFF_DEC_AUDIO_MIDI: next_state.cfg.audioMidi = wb & WMASK_AUDIO_MIDI;
                  OFF_DEC_SOUND_SIO: next_state.cfg.soundSio = wb & WMASK_SOUND_SIO;
                  OFF_DEC_GAME_A: next_state.cfg.gameA = wb & WMASK_GAME;
                  OFF_DEC_GAME_B: next_state.cfg.gameB = wb & WMASK_GAME;
                  OFF_GENERIC_B1: next_state.cfg.genericWindowBase = wb[7:1];
                  default: begin
                  end
               endcase
            end
            next_state.rdData[lane*8 +: 8] = (!cfgWr && cfgByteEn[lane])
                                             ? readByte(state.cfg, off) : 8'h00;
         end
         next_state.rdValid = ~cfgWr;
      end

      // IO decode, answered one cycle later
      if (ioReq) begin
         next_state.ioDone = 1'b1;
         next_state.io = decodeIo(state.cfg, ioAddr, ioWrite, usbEmulationControl);
      end

      // Memory cycle against the interrupt-controller window
      if (memReq) begin
         memDelta = memAddr - INTR_WIN_BASE;
         next_state.memDone = 1'b1;
         next_state.memInWindow = (memAddr >= INTR_WIN_BASE) && (memDelta < INTR_WIN_SIZE);
         next_state.memToIntr = next_state.memInWindow
                                && state.cfg.intrCfg.intrCtrlEnable;
         next_state.memToLegacy = next_state.memInWindow
                                  && !state.cfg.intrCfg.intrCtrlEnable;
      end
   end

   // ****************************************
   // Register
   // ****************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= '0;
         state.cfg.genericWindowBase <= RST_GENERIC_BASE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign cfgRdData = state.rdData;
   assign cfgRdValid = state.rdValid;
   assign ioDone = state.ioDone;
   assign ioHit = state.io.hit;
   assign ioToLpc = state.io.toLpc;
   assign ioToIsa = state.io.toIsa;
   assign ioToUsb = state.io.toUsb;
   assign memDone = state.memDone;
   assign memInWindow = state.memInWindow;
   assign memToLegacy = state.memToLegacy;
   assign memToIntr = state.memToIntr;
   // Message bus idles whenever the controller is off
   assign intrMsgBusEnable = state.cfg.intrCfg.intrCtrlEnable;

endmodule : lid_legacy_io_decoder

// ==== tb/lid_decoder_props.sv ====
// Port-level checker for the legacy IO decoder.
// Assumes one mclk domain and bind onto lid_legacy_io_decoder.
`timescale 1ns/1ps
module lid_decoder_props (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Config access
   input wire logic cfgSel,
   input wire logic cfgWr,
   input wire logic [5:0] cfgDwordAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   input wire logic cfgRdValid,
   // Decode
   input wire logic ioReq,
   input wire logic [15:0] ioAddr,
   input wire logic usbEmulationControl,
   input wire logic ioDone,
   input wire logic ioHit,
   input wire logic ioToLpc,
   input wire logic ioToIsa,
   input wire logic ioToUsb,
   input wire logic memReq,
   input wire logic memDone,
   input wire logic memInWindow,
   input wire logic memToLegacy,
   input wire logic memToIntr,
   input wire logic intrMsgBusEnable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence ioTake;
      ce && ioReq;
   endsequence
   sequence routed;
      ioDone && $onehot({ioToLpc, ioToIsa, ioToUsb});
   endsequence
   AST_IO_DONE: assert property (ioTake |=> routed)
      else $error("io result missing");
   AST_IO_HOLD: assert property (ce && !ioReq |=> !ioDone && $stable({ioToLpc, ioToIsa}))
      else $error("io result moved");
   AST_MISS_ISA: assert property (ioDone && !ioHit |-> ioToIsa)
      else $error("miss not on isa");
   AST_KBD_USB: assert property (ioTake ##0 (usbEmulationControl && ioAddr[15:3] == 13'h000C
      && ioAddr[1:0] == 2'b00) |=> ioToUsb)
      else $error("keyboard not to usb");
   AST_MSG_EN: assert property (ce && cfgSel && cfgWr && cfgDwordAddr == 6'h12 && cfgByteEn[3]
      |=> intrMsgBusEnable == $past(cfgWrData[24]))
      else $error("msg bus enable wrong");
   // Route uses the enable as it stood when the cycle was taken
   AST_MEM_ROUTE: assert property (memDone && memInWindow
      |-> memToIntr == $past(intrMsgBusEnable) && memToLegacy != memToIntr)
      else $error("mem route wrong");
   AST_MEM_DONE: assert property (ce && memReq |=> memDone)
      else $error("mem result missing");
   AST_RD_VALID: assert property (ce && cfgSel && !cfgWr |=> cfgRdValid)
      else $error("read answer missing");
   AST_HIT_LPC: assert property (ioDone && !ioToIsa |-> ioHit)
      else $error("routed cycle without hit");
   AST_CE_HOLD: assert property (!ce |=> $stable({ioDone, ioHit, ioToLpc, ioToIsa, ioToUsb,
      memDone, cfgRdValid, intrMsgBusEnable}))
      else $error("state moved with enable low");
endmodule : lid_decoder_props

bind lid_legacy_io_decoder lid_decoder_props props (.mclk(mclk), .rst(rst), .ce(ce),
   .cfgSel(cfgSel), .cfgWr(cfgWr), .cfgDwordAddr(cfgDwordAddr), .cfgByteEn(cfgByteEn),
   .cfgWrData(cfgWrData), .cfgRdValid(cfgRdValid), .ioReq(ioReq), .ioAddr(ioAddr),
   .usbEmulationControl(usbEmulationControl), .ioDone(ioDone), .ioHit(ioHit),
   .ioToLpc(ioToLpc), .ioToIsa(ioToIsa), .ioToUsb(ioToUsb), .memReq(memReq),
   .memDone(memDone), .memInWindow(memInWindow), .memToLegacy(memToLegacy),
   .memToIntr(memToIntr), .intrMsgBusEnable(intrMsgBusEnable));

// ==== tb/lid_usb_emu_model.sv ====
// USB block model giving the keyboard emulation level.
// Assumes the decoder's mclk; no synchroniser needed.
`timescale 1ns/1ps
module lid_usb_emu_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bench control
   input wire logic reqOn,
   // To decoder
   output logic usbEmulationControl
);
   // Registered, so a change lands one edge late
   always_ff @(posedge mclk) begin
      usbEmulationControl <= rst ? 1'b0 : reqOn;
   end
endmodule : lid_usb_emu_model

// ==== tb/tb_legacy_io_lpc_isa_decoder.sv ====
// Directed bench for the legacy IO decoder.
// Assumes ce high except one freeze check; requests last one cycle, with one idle cycle between.
`timescale 1ns/1ps
module tb_legacy_io_lpc_isa_decoder;
   import lid_pkg::*;
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin error_cnt++; \
   $display("ERROR %s exp %h got %h", nm, ex, ac); end end
   localparam logic [2:0] LPC_R = 3'b100, ISA_R = 3'b010, USB_R = 3'b001;
   logic mclk, rst = 1, ce = 1, cfgSel = 0, cfgWr = 0, ioReq = 0, ioWrite = 0, memReq = 0;
   logic usbOn = 0, cfgRdValid, ioDone, ioHit, ioToLpc, ioToIsa, ioToUsb, memDone;
   logic memInWindow, memToLegacy, memToIntr, intrMsgBusEnable, usbEmulationControl;
   logic [5:0] cfgDwordAddr = 0;
   logic [3:0] cfgByteEn = 0;
   logic [31:0] cfgWrData = 0, memAddr = 0, cfgRdData;
   logic [15:0] ioAddr = 0;
   logic [15:0] pb [3] = '{16'h03BC, 16'h0378, 16'h0278};
   logic [15:0] sb [8] = '{16'h03F8, 16'h02F8, 16'h0220, 16'h0228, 16'h0238, 16'h02E8,
      16'h0338, 16'h03E8};
   logic [15:0] ss [4] = '{16'h0530, 16'h0604, 16'h0E80, 16'h0F40};
   logic [15:0] fl [10] = '{16'h03F0, 16'h03F5, 16'h03F7, 16'h0370, 16'h0375, 16'h0377,
      16'h0062, 16'h0066, 16'h0060, 16'h0064};
   logic [15:0] fx [6] = '{16'h0388, 16'h0389, 16'h002E, 16'h002F, 16'h004E, 16'h004F};
   int error_cnt = 0, checks = 0;
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   lid_legacy_io_decoder uut (.mclk(mclk), .rst(rst), .ce(ce), .cfgSel(cfgSel),
      .cfgWr(cfgWr), .cfgDwordAddr(cfgDwordAddr), .cfgByteEn(cfgByteEn),
      .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
      .ioReq(ioReq), .ioAddr(ioAddr), .ioWrite(ioWrite),
      .usbEmulationControl(usbEmulationControl), .ioDone(ioDone), .ioHit(ioHit),
      .ioToLpc(ioToLpc), .ioToIsa(ioToIsa), .ioToUsb(ioToUsb), .memReq(memReq),
      .memAddr(memAddr), .memDone(memDone), .memInWindow(memInWindow),
      .memToLegacy(memToLegacy), .memToIntr(memToIntr), .intrMsgBusEnable(intrMsgBusEnable));
   lid_usb_emu_model usb (.mclk(mclk), .rst(rst), .reqOn(usbOn),
      .usbEmulationControl(usbEmulationControl));
   task automatic cfg(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d,
      input logic wr);
      @(posedge mclk) #1;
      cfgSel = 1;
      cfgWr = wr;
      cfgDwordAddr = a;
      cfgByteEn = be;
      cfgWrData = d;
      @(posedge mclk) #1;
      cfgSel = 0;
   endtask : cfg
   task automatic rd(input logic [5:0] a, input logic [31:0] ex);
      cfg(a, 4'hF, 32'h0000_0000, 1'b0);
      `CHK("cfgRead", {1'b1, ex}, {cfgRdValid, cfgRdData})
   endtask : rd
   task automatic wr8(input logic [7:0] off, input logic [7:0] d);
      cfg(off[7:2], 4'b0001 << off[1:0], {24'h00_0000, d} << (8 * off[1:0]), 1'b1);
   endtask : wr8
   task automatic io(input logic [15:0] a, input logic [2:0] ex, input logic wr = 1'b0);
      @(posedge mclk) #1;
      ioReq = 1;
      ioAddr = a;
      ioWrite = wr;
      @(posedge mclk) #1;
      ioReq = 0;
      `CHK("ioRoute", {1'b1, ex}, {ioDone, ioToLpc, ioToIsa, ioToUsb})
   endtask : io
   task automatic mem(input logic [31:0] a, input logic [4:0] ex);
      @(posedge mclk) #1;
      memReq = 1;
      memAddr = a;
      @(posedge mclk) #1;
      memReq = 0;
      `CHK("memRoute", ex, {memDone, memInWindow, memToLegacy, memToIntr, intrMsgBusEnable})
   endtask : mem
   task automatic conclude();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(posedge mclk);
      #1 rst = 0;
      rd(6'h12, 32'h0000_0000);
      rd(6'h14, 32'h0000_0000);
      rd(6'h15, 32'h0000_0000);
      rd(6'h17, 32'h0000_0000);
      rd(6'h16, 32'h0000_DE01);
      io(16'hDE00, LPC_R);
      io(16'hDFFF, LPC_R);
      io(16'hE000, ISA_R);
      wr8(8'h59, 8'h00);
      rd(6'h16, 32'h0000_0001);
      io(16'hDE00, ISA_R);
      for (int c = 0; c < 3; c++) begin
         wr8(8'h51, {6'b0000_10, 2'(c)});
         io(pb[c], LPC_R);
         io(pb[c] + (c == 0 ? 16'h0003 : 16'h0007), LPC_R);
         io(pb[c] - 16'h0001, ISA_R);
         io(pb[c] + 16'h0400, LPC_R);
      end
      io(16'h0279, ISA_R, 1'b1);
      io(16'h0279, LPC_R);
      wr8(8'h51, 8'h01);
      io(16'h0778, ISA_R);
      wr8(8'h51, 8'hF3);
      io(16'h0378, ISA_R);
      io(16'h03F6, ISA_R);
      foreach (fl[i]) io(fl[i], LPC_R);
      usbOn = 1;
      io(16'h0060, USB_R);
      io(16'h0064, USB_R);
      usbOn = 0;
      wr8(8'h51, 8'h03);
      foreach (fl[i]) io(fl[i], ISA_R);
      for (int c = 0; c < 8; c++) begin
         wr8(8'h52, {1'b0, 3'(c + 1), 1'b1, 3'(c)});
         io(sb[c], LPC_R);
         io(sb[c] + 16'h0007, LPC_R);
         io(sb[(c + 1) % 8], ISA_R);
      end
      wr8(8'h52, 8'h90);
      io(16'h02F8, LPC_R);
      io(16'h03F8, ISA_R);
      for (int c = 0; c < 4; c++) begin
         wr8(8'h53, {2'b01, 2'(c), 2'b11, 2'(c)});
         wr8(8'h54, {4'b0011, 2'b01, 2'(c)});
         io(16'h0220 + 16'h0020 * 16'(c), LPC_R);
         io(16'h0233 + 16'h0020 * 16'(c), LPC_R);
         io(16'h0234 + 16'h0020 * 16'(c), ISA_R);
         io(16'h0300 + 16'h0010 * 16'(c), LPC_R);
         io(16'h0302 + 16'h0010 * 16'(c), ISA_R);
         io(ss[c] + 16'h0007, LPC_R);
         io(ss[c] + 16'h0008, ISA_R);
      end
      foreach (fx[i]) io(fx[i], LPC_R);
      wr8(8'h53, 8'h00);
      wr8(8'h54, 8'h00);
      foreach (fx[i]) io(fx[i], ISA_R);
      wr8(8'h52, 8'h0A);
      io(16'h0220, LPC_R);
      wr8(8'h55, 8'h15);
      wr8(8'h56, 8'h1A);
      io(16'h0205, LPC_R);
      io(16'h020A, LPC_R);
      io(16'h0206, ISA_R);
      wr8(8'h56, 8'h0A);
      io(16'h020A, ISA_R);
      io(16'h0205, LPC_R);
      // Enable low: last result stands although 206h would go to ISA
      ce = 0;
      io(16'h0206, LPC_R);
      ce = 1;
      mem(32'hFEC0_0000, 5'b1_1100);
      wr8(8'h4B, 8'h01);
      mem(32'hFEC0_0FFF, 5'b1_1011);
      rd(6'h12, 32'h0100_0000);
      conclude();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      conclude();
   end
endmodule : tb_legacy_io_lpc_isa_decoder
